// [hw/tgc_pkg.sv]
// timer gate control package: offsets, field positions, reset values
// assumes a 32-bit avalon-mm data path with byte addresses
package tgc_pkg;
  // register byte addresses
  localparam logic [3:0] TGC_GATE_CTRL_OFS = 4'h0;
  localparam logic [3:0] TGC_TIMER_CTRL_OFS = 4'h4;
  // gate control field positions
  localparam int TGC_GE_BIT   = 7;
  localparam int TGC_POL_BIT  = 6;
  localparam int TGC_TM_BIT   = 5;
  localparam int TGC_SPM_BIT  = 4;
  localparam int TGC_GO_BIT   = 3;
  localparam int TGC_VAL_BIT  = 2;
  localparam int TGC_SS_LSB   = 0;
  // timer control field position
  localparam int TGC_ON_BIT   = 0;
  // reset values
  localparam logic [7:0] TGC_GATE_CTRL_RST = 8'h00;
  localparam logic       TGC_ON_RST        = 1'h0;
  localparam logic [1:0] TGC_SS_RST        = 2'h0;
  // gate source codes
  typedef enum logic [1:0] {
    TGC_SRC_PIN  = 2'b00,
    TGC_SRC_OVF  = 2'b01,
    TGC_SRC_CMP1 = 2'b10,
    TGC_SRC_CMP2 = 2'b11
  } tgc_src_e;
  // bus handshake states
  typedef enum logic [0:0] {
    TGC_BUS_IDLE = 1'b0,
    TGC_BUS_ACK  = 1'b1
  } tgc_bus_e;
endpackage

// [hw/tgc_gate.sv]
// timer gate control: gate source, polarity, toggle and live level
// assumes avalon-mm master on mclk; overflow and comparator inputs
// are already on mclk, the gate pin is asynchronous
//
// Contract
// - polarity bit set gives active-high gate
// - toggle mode drives gate from toggle flop
// - toggle mode clear holds toggle flop cleared
// - toggle flop flips on each source rising edge
// - read-only gate level bit shows live gate
// - gate level independent of gate enable
//
// Design decisions made here: the register addresses and the Avalon-MM register port.
`timescale 1ns/10ps
module tgc_gate
  import tgc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        gate_pin,
  input  wire logic        timer_overflow,
  input  wire logic        comp1_sync,
  input  wire logic        comp2_sync,
  output logic             gate_level_out,
  output logic             count_enable
);
  import tgc_pkg::*;

  logic       pin_s1_q;
  logic       pin_s2_q;
  logic       ge_q;
  logic       pol_q;
  logic       tm_q;
  logic       spm_q;
  logic [1:0] ss_q;
  logic       on_q;
  logic       tog_q;
  logic       src_prev_q;
  logic       gate_level_q;
  logic       count_en_q;
  logic [31:0] rdata_q;
  tgc_bus_e   bus_q;
  logic       wait_q;
  logic       src;
  logic       src_rise;
  logic       gate_raw;
  logic       gate_level_d;
  logic       req;
  logic       wr_take;
  logic [31:0] rdata_d;

  // byte lane 0 carries every implemented field
  function automatic logic lane0(input logic [3:0] be);
    return be[0];
  endfunction

  // two-flop synchroniser for the asynchronous gate pin
  always_ff @(posedge mclk) begin
    if (reset) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
    end else begin
      pin_s1_q <= gate_pin;
      pin_s2_q <= pin_s1_q;
    end
  end

  // gate source mux
  always_comb begin
    case (tgc_src_e'(ss_q))
      TGC_SRC_PIN:  src = pin_s2_q;
      TGC_SRC_OVF:  src = timer_overflow;
      TGC_SRC_CMP1: src = comp1_sync;
      TGC_SRC_CMP2: src = comp2_sync;
      default:      src = pin_s2_q;
    endcase
  end

  assign src_rise = src & ~src_prev_q;

  // previous source level for edge detection
  always_ff @(posedge mclk) begin
    if (reset) begin
      src_prev_q <= 1'b0;
    end else begin
      src_prev_q <= src;
    end
  end

  // toggle flop; held clear whenever toggle mode is off
  always_ff @(posedge mclk) begin
    if (reset) begin
      tog_q <= 1'b0;
    end else if (!tm_q) begin
      tog_q <= 1'b0;
    end else if (src_rise) begin
      tog_q <= ~tog_q;
    end
  end

  // toggle output replaces the raw level, then polarity applies
  assign gate_raw = tm_q ? tog_q : src;
  assign gate_level_d = pol_q ? gate_raw : ~gate_raw;

  // live gate level; gate enable deliberately not involved
  always_ff @(posedge mclk) begin
    if (reset) begin
      gate_level_q <= 1'b0;
    end else begin
      gate_level_q <= gate_level_d;
    end
  end

  // count enable: timer off wins, gate enable off counts freely
  always_ff @(posedge mclk) begin
    if (reset) begin
      count_en_q <= 1'b0;
    end else begin
      count_en_q <= on_q & (~ge_q | gate_level_d);
    end
  end

  // one wait cycle per access keeps readdata registered
  assign req = (avs_read | avs_write) & (bus_q == TGC_BUS_IDLE);
  assign wr_take = avs_write & (bus_q == TGC_BUS_ACK);

  always_ff @(posedge mclk) begin
    if (reset) begin
      bus_q <= TGC_BUS_IDLE;
    end else begin
      case (bus_q)
        TGC_BUS_IDLE: bus_q <= req ? TGC_BUS_ACK : TGC_BUS_IDLE;
        TGC_BUS_ACK:  bus_q <= TGC_BUS_IDLE;
        default:      bus_q <= TGC_BUS_IDLE;
      endcase
    end
  end

  // waitrequest from its own flop so the pin never sees decode glitches
  always_ff @(posedge mclk) begin
    if (reset) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~req;
    end
  end

  // gate control write; go/done and gate level are not stored
  always_ff @(posedge mclk) begin
    if (reset) begin
      ge_q  <= TGC_GATE_CTRL_RST[TGC_GE_BIT];
      pol_q <= TGC_GATE_CTRL_RST[TGC_POL_BIT];
      tm_q  <= TGC_GATE_CTRL_RST[TGC_TM_BIT];
      spm_q <= TGC_GATE_CTRL_RST[TGC_SPM_BIT];
      ss_q  <= TGC_SS_RST;
    end else if (wr_take && avs_address == TGC_GATE_CTRL_OFS
                 && lane0(avs_byteenable)) begin
      ge_q  <= avs_writedata[TGC_GE_BIT];
      pol_q <= avs_writedata[TGC_POL_BIT];
      tm_q  <= avs_writedata[TGC_TM_BIT];
      spm_q <= avs_writedata[TGC_SPM_BIT];
      ss_q  <= avs_writedata[TGC_SS_LSB +: 2];
    end
  end

  // timer on bit lives in its own word
  always_ff @(posedge mclk) begin
    if (reset) begin
      on_q <= TGC_ON_RST;
    end else if (wr_take && avs_address == TGC_TIMER_CTRL_OFS
                 && lane0(avs_byteenable)) begin
      on_q <= avs_writedata[TGC_ON_BIT];
    end
  end

  // read mux; unmapped words read as zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (avs_address)
      TGC_GATE_CTRL_OFS: begin
        rdata_d[TGC_GE_BIT]  = ge_q;
        rdata_d[TGC_POL_BIT] = pol_q;
        rdata_d[TGC_TM_BIT]  = tm_q;
        rdata_d[TGC_SPM_BIT] = spm_q;
        rdata_d[TGC_VAL_BIT] = gate_level_q;
        rdata_d[TGC_SS_LSB +: 2] = ss_q;
      end
      TGC_TIMER_CTRL_OFS: rdata_d[TGC_ON_BIT] = on_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata_q <= 32'h0000_0000;
    end else if (req && avs_read) begin
      rdata_q <= rdata_d;
    end
  end

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign gate_level_out  = gate_level_q;
  assign count_enable    = count_en_q;

  // checks
  sequence s_src_high_direct;
    (!tm_q && pol_q && src) [*2];
  endsequence

  sequence s_src_low_direct_inv;
    (!tm_q && !pol_q && !src) [*2];
  endsequence

  sequence s_free_run;
    (on_q && !ge_q) [*2];
  endsequence

  sequence s_read_gate_ctrl;
    avs_read && req && avs_address == TGC_GATE_CTRL_OFS;
  endsequence

  AST_POL_HIGH: assert property (@(posedge mclk) disable iff (reset)
    s_src_high_direct |-> gate_level_q)
    else $error("active-high gate not high");

  AST_POL_LOW: assert property (@(posedge mclk) disable iff (reset)
    s_src_low_direct_inv |-> gate_level_q)
    else $error("active-low gate not high on low source");

  AST_TOG_USED: assert property (@(posedge mclk) disable iff (reset)
    tm_q && !src_rise |=> gate_level_q == ($past(pol_q) ? $past(tog_q) : !$past(tog_q)))
    else $error("toggle mode gate not from toggle flop");

  AST_TOG_CLEAR: assert property (@(posedge mclk) disable iff (reset)
    !tm_q |=> !tog_q)
    else $error("toggle flop not cleared");

  AST_TOG_FLIP: assert property (@(posedge mclk) disable iff (reset)
    tm_q && src_rise |=> tog_q != $past(tog_q))
    else $error("toggle flop missed rising edge");

  AST_TOG_HOLD: assert property (@(posedge mclk) disable iff (reset)
    tm_q && !src_rise |=> $stable(tog_q))
    else $error("toggle flop moved without edge");

  AST_VAL_READ: assert property (@(posedge mclk) disable iff (reset)
    s_read_gate_ctrl |=> !avs_waitrequest && avs_readdata[TGC_VAL_BIT] == $past(gate_level_q))
    else $error("gate level bit wrong on read");

  AST_VAL_NO_GE: assert property (@(posedge mclk) disable iff (reset)
    !ge_q && !$past(reset) |-> gate_level_q == $past(gate_level_d))
    else $error("gate level lost with gate enable clear");

  AST_OFF_STOP: assert property (@(posedge mclk) disable iff (reset)
    !on_q |=> !count_enable)
    else $error("counting while timer off");

  AST_FREE_RUN: assert property (@(posedge mclk) disable iff (reset)
    s_free_run |=> count_enable)
    else $error("ungated timer not counting");

  AST_GATED: assert property (@(posedge mclk) disable iff (reset)
    on_q && ge_q |=> count_enable == gate_level_q)
    else $error("gated count does not follow gate");

  // each source code routes its own input straight to the gate
  AST_SRC_PIN: assert property (@(posedge mclk) disable iff (reset)
    !tm_q && pol_q && ss_q == TGC_SRC_PIN |=> gate_level_q == $past(pin_s2_q))
    else $error("pin source not routed to gate");

  AST_SRC_OVF: assert property (@(posedge mclk) disable iff (reset)
    !tm_q && pol_q && ss_q == TGC_SRC_OVF |=> gate_level_q == $past(timer_overflow))
    else $error("overflow source not routed to gate");

  AST_SRC_CMP1: assert property (@(posedge mclk) disable iff (reset)
    !tm_q && pol_q && ss_q == TGC_SRC_CMP1 |=> gate_level_q == $past(comp1_sync))
    else $error("first comparator source not routed to gate");

  AST_SRC_CMP2: assert property (@(posedge mclk) disable iff (reset)
    !tm_q && pol_q && ss_q == TGC_SRC_CMP2 |=> gate_level_q == $past(comp2_sync))
    else $error("second comparator source not routed to gate");

  // toggle mode with a cleared flop keeps an active-high gate shut
  AST_TOG_SHUT: assert property (@(posedge mclk) disable iff (reset)
    tm_q && !tog_q && pol_q |=> !gate_level_q)
    else $error("toggle mode gate open with flop clear");

  // timer on: count window opens with the gate, and shuts with it while gate enable is set
  AST_GATE_OPEN: assert property (@(posedge mclk) disable iff (reset)
    on_q && gate_level_d |=> count_enable)
    else $error("open gate does not count");

  AST_GATE_CLOSED: assert property (@(posedge mclk) disable iff (reset)
    on_q && ge_q && !gate_level_d |=> !count_enable)
    else $error("closed gate still counting");

  // the waitrequest flop must agree with the handshake state
  AST_WAIT_STATE: assert property (@(posedge mclk) disable iff (reset)
    avs_waitrequest == (bus_q != TGC_BUS_ACK))
    else $error("waitrequest out of step with bus state");
endmodule

// [verif/testbench.sv]
// testbench: self-checking bench for the timer gate control block
// assumes tgc_gate on mclk with an avalon-mm slave port
`timescale 1ns/10ps
module testbench;
  import tgc_pkg::*;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        gate_pin = 1'b0;
  logic        timer_overflow = 1'b0;
  logic        comp1_sync = 1'b0;
  logic        comp2_sync = 1'b0;
  logic        gate_level_out;
  logic        count_enable;
  logic [31:0] q;
  int          miscompares = 0;
  int          comparisons = 0;

  // 40 MHz clock
  always #12.5 mclk = ~mclk;

  tgc_gate i_dut (.mclk(mclk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .gate_pin(gate_pin),
    .timer_overflow(timer_overflow), .comp1_sync(comp1_sync), .comp2_sync(comp2_sync),
    .gate_level_out(gate_level_out), .count_enable(count_enable));

  task automatic tally_and_finish;
    if (miscompares == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // one bus access; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    for (n = 0; n < 20; n++) begin
      @(posedge mclk);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (n == 20) begin
      miscompares++;
      $display("[ERR] waitrequest expected 0 seen 1");
      tally_and_finish();
    end
  endtask

  // reset values, read-only and unmapped places, byte enable
  task automatic t_regs;
    bus(0, 4'h0, 0); chk("ctrl_rst", q, 32'h04);
    bus(0, 4'h4, 0); chk("on_rst", q, 32'h0);
    bus(1, 4'h8, 32'hFF); bus(0, 4'h8, 0); chk("unmapped", q, 32'h0);
    bus(1, 4'h0, 32'hFFFFFFFF); bus(0, 4'h0, 0); chk("ctrl_ro", q, 32'hF3);
    avs_byteenable <= 4'hE;
    bus(1, 4'h0, 32'h0); bus(0, 4'h0, 0); chk("be_off", q, 32'hF3);
    avs_byteenable <= 4'hF;
    bus(1, 4'h0, 32'h0);
    bus(1, 4'h4, 32'hFFFFFFFF); bus(0, 4'h4, 0); chk("on_rw", q, 32'h1);
  endtask

  // every source code with both polarities
  task automatic t_src;
    for (int s = 0; s < 4; s++) begin
      bus(1, 4'h0, 32'h40 | s);
      gate_pin <= (s == 0); timer_overflow <= (s == 1); comp1_sync <= (s == 2); comp2_sync <= (s == 3);
      wt(5); chk("lvl_hi", gate_level_out, 1);
      bus(0, 4'h0, 0); chk("val_hi", q, 32'h44 | s);
      gate_pin <= (s != 0); timer_overflow <= (s != 1); comp1_sync <= (s != 2); comp2_sync <= (s != 3);
      wt(5); chk("lvl_lo", gate_level_out, 0);
      bus(1, 4'h0, 32'h00 | s);
      wt(3); chk("lvl_inv", gate_level_out, 1);
    end
    comp1_sync <= 0; comp2_sync <= 0; gate_pin <= 0; timer_overflow <= 0;
  endtask

  // gate enable against timer on
  task automatic t_enable;
    bus(1, 4'h4, 0); bus(1, 4'h0, 32'hC1); timer_overflow <= 1;
    wt(4); chk("ce_off", count_enable, 0);
    bus(1, 4'h4, 1); timer_overflow <= 0;
    wt(4); chk("ce_gated_lo", count_enable, 0);
    timer_overflow <= 1;
    wt(4); chk("ce_gated_hi", count_enable, 1);
    bus(1, 4'h0, 32'h41); bus(0, 4'h0, 0); chk("val_ge0", q, 32'h45);
    timer_overflow <= 0;
    wt(4); chk("ce_free", count_enable, 1);
  endtask

  // toggle flop: one flip per rising edge, cleared while mode is off
  task automatic t_toggle;
    bus(1, 4'h0, 32'h61);
    wt(3); chk("tog_init", gate_level_out, 0);
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk) timer_overflow <= 1;
      @(posedge mclk) timer_overflow <= 0;
      wt(4); chk("tog_flip", gate_level_out, (k == 0));
    end
    timer_overflow <= 1;
    wt(6); chk("tog_level", gate_level_out, 1);
    bus(1, 4'h0, 32'h41); bus(1, 4'h0, 32'h61);
    wt(3); chk("tog_clr", gate_level_out, 0);
    timer_overflow <= 0;
  endtask

  initial begin
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    t_regs();
    t_src();
    t_enable();
    t_toggle();
    tally_and_finish();
  end
endmodule
